//--- core/sem_host.sv
// Contract
// - write zero claims, write one releases
// - semaphore_select_n low selects flag space
// - acquire is write zero then read
// - after failure, poll or write one
// - strobes go high between successive reads
// - init writes one to every flag
// - chip enable high, select low for access
`timescale 1ns/100ps
module sem_host
    import sem_host_pkg::*;
#(
    parameter int SETUP_CYC = SETUP_CYCLES,
    parameter int STROBE_CYC = STROBE_CYCLES,
    parameter int RECOVER_CYC = RECOVER_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cmd_type cmd,
    input wire logic [INDEX_WIDTH-1:0] cmd_index,
    output logic result_valid,
    output result_type result,
    output pins_type pins,
    input wire logic [DATA_WIDTH-1:0] data_in,
    output logic [DATA_WIDTH-1:0] data_out,
    output logic [DATA_WIDTH-1:0] data_oe
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER,
        ST_DONE
    } state_type;

    state_type state_reg, state_next;
    logic [3:0] count_reg, count_next;
    logic is_read_reg, is_read_next;
    logic wbit_reg, wbit_next;
    logic [INDEX_WIDTH-1:0] idx_reg, idx_next;
    cmd_type cmd_reg, cmd_next;
    logic [DATA_WIDTH-1:0] sync1_reg, sync2_reg;
    logic granted_reg, granted_next;
    logic result_valid_reg, result_valid_next;
    logic last_init;
    logic count_done;
    logic [3:0] setup_c, strobe_c, recover_c;
    logic read_zero;
    result_type result_next;
    logic load_result;

    // a release or an init walk writes a one; a failed claim must be
    // followed by one of these or by polls, or its latch stays pending
    function automatic logic writes_one(cmd_type c);
        return (c == CMD_RELEASE) || (c == CMD_INIT);
    endfunction

    // only a poll starts with a read; a claim always writes first
    function automatic logic reads_first(cmd_type c);
        return (c == CMD_POLL);
    endfunction

    assign setup_c = 4'(SETUP_CYC - 1);
    assign strobe_c = 4'(STROBE_CYC - 1);
    assign recover_c = 4'(RECOVER_CYC - 1);
    assign count_done = (count_reg == CNT_ZERO);
    assign last_init = (idx_reg == INDEX_WIDTH'(FLAG_COUNT - 1));
    // a flag reads all zeros when owned by this side
    assign read_zero = ~sync2_reg[0];
    assign cmd_ready = (state_reg == ST_IDLE);
    assign result_valid = result_valid_reg;
    // result stands from one answer until the next command completes
    assign load_result = result_valid_next;
    assign result_next = '{granted: granted_reg,
                           flag_index: idx_reg};

    // two stages before anything reads the device data pins
    always_ff @(posedge clk) begin
        if (clk_en) begin
            sync1_reg <= data_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        is_read_next = is_read_reg;
        wbit_next = wbit_reg;
        idx_next = idx_reg;
        cmd_next = cmd_reg;
        granted_next = granted_reg;
        result_valid_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (cmd_valid) begin
                    cmd_next = cmd;
                    idx_next = (cmd == CMD_INIT) ? '0 : cmd_index;
                    // acquire writes zero first, never reads first
                    is_read_next = reads_first(cmd);
                    wbit_next = writes_one(cmd);
                    count_next = setup_c;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address and select settle before any strobe
                if (count_done) begin
                    count_next = strobe_c;
                    state_next = ST_STROBE;
                end else begin
                    count_next = count_reg - 4'h1;
                end
            end
            ST_STROBE: begin
                // sample once the synchronised data has followed the strobe
                if (count_done) begin
                    if (is_read_reg) begin
                        granted_next = read_zero;
                    end
                    count_next = recover_c;
                    state_next = ST_RECOVER;
                end else begin
                    count_next = count_reg - 4'h1;
                end
            end
            ST_RECOVER: begin
                // strobes stay high here, so next read relatches
                if (!count_done) begin
                    count_next = count_reg - 4'h1;
                end else if (cmd_reg == CMD_ACQUIRE && !is_read_reg) begin
                    is_read_next = 1'b1;
                    count_next = setup_c;
                    state_next = ST_SETUP;
                end else if (cmd_reg == CMD_INIT && !last_init) begin
                    // every flag in turn, so no stale request survives
                    idx_next = idx_reg + INDEX_WIDTH'(1);
                    count_next = setup_c;
                    state_next = ST_SETUP;
                end else begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                // one-cycle answer; result loads on the same edge
                result_valid_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // the device flags survive this reset; software issues an init
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            count_reg <= CNT_ZERO;
            is_read_reg <= 1'b0;
            wbit_reg <= 1'b1;
            idx_reg <= '0;
            cmd_reg <= CMD_POLL;
            granted_reg <= 1'b0;
            result_valid_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            count_reg <= count_next;
            is_read_reg <= is_read_next;
            wbit_reg <= wbit_next;
            idx_reg <= idx_next;
            cmd_reg <= cmd_next;
            granted_reg <= granted_next;
            result_valid_reg <= result_valid_next;
        end
    end

    // pins lag the state by one register: select falls one cycle into
    // setup, the strobe pins follow one cycle into strobe, and recover
    // keeps every strobe high so the device relatches on the next read
    // and a pending write is closed before the next access begins
    logic active;
    logic strobe;
    assign active = (state_reg == ST_SETUP) || (state_reg == ST_STROBE);
    assign strobe = (state_reg == ST_STROBE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // idle bus: every strobe inactive, nothing driven
            pins <= '{chip_enable_n: 1'b1, semaphore_select_n: 1'b1,
                      output_enable_n: 1'b1, read_write_n: 1'b1,
                      address: '0};
            data_out <= '0;
            data_oe <= '0;
            result <= '0;
        end else if (clk_en) begin
            // chip enable stays high: only the flag space is ever selected
            pins.chip_enable_n <= 1'b1;
            pins.semaphore_select_n <= ~active;
            pins.output_enable_n <= ~(strobe && is_read_reg);
            pins.read_write_n <= ~(strobe && !is_read_reg);
            pins.address <= {{(ADDR_WIDTH-INDEX_WIDTH){1'b0}},
                             idx_reg};
            // only bit zero carries the flag value; the rest idle high
            data_out <= {{(DATA_WIDTH-1){1'b1}}, wbit_reg};
            data_oe <= {DATA_WIDTH{active && !is_read_reg}};
            if (load_result) begin
                result <= result_next;
            end
        end
    end
endmodule // sem_host

//--- core/sem_host_pkg.sv
package sem_host_pkg;
    localparam int FLAG_COUNT = 8;
    localparam int INDEX_WIDTH = 3;
    localparam int DATA_WIDTH = 9;
    localparam int ADDR_WIDTH = 13;
    // bus timing, in ns, and derived cycles at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 40;
    localparam int RECOVER_NS = 20;
    localparam int SETUP_CYCLES =
        (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYCLES =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYCLES =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        CMD_ACQUIRE,
        CMD_RELEASE,
        CMD_POLL,
        CMD_INIT
    } cmd_type;

    typedef struct packed {
        logic chip_enable_n;
        logic semaphore_select_n;
        logic output_enable_n;
        logic read_write_n;
        logic [ADDR_WIDTH-1:0] address;
    } pins_type;

    typedef struct packed {
        logic granted;
        logic [INDEX_WIDTH-1:0] flag_index;
    } result_type;
endpackage

//--- bench/sem_host_props.sv
`timescale 1ns/100ps
module sem_host_props
    import sem_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire cmd_type cmd,
    input wire logic result_valid,
    input wire pins_type pins,
    input wire logic [DATA_WIDTH-1:0] data_out,
    input wire logic [DATA_WIDTH-1:0] data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire sel = !pins.semaphore_select_n;
    wire wr = sel && !pins.read_write_n;
    wire take = cmd_valid && cmd_ready;
    a_chip_high: assert property (pins.chip_enable_n)
        else $error("chip enable low");
    a_write_lsb: assert property (wr |-> &data_oe && &data_out[8:1])
        else $error("write data bad");
    a_high_addr: assert property (sel |-> pins.address[12:3] == '0)
        else $error("high address set");
    a_read_quiet: assert property (!pins.output_enable_n |->
        sel && pins.read_write_n && data_oe == '0) else $error("read bad");
    a_take_busy: assert property (take |=> !cmd_ready)
        else $error("ready while busy");
    a_acq_done: assert property (take && cmd == CMD_ACQUIRE
        |-> ##[17:30] result_valid) else $error("acquire late");
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("valid too long");
    a_sel_gap: assert property ($rose(pins.semaphore_select_n)
        |=> pins.semaphore_select_n) else $error("no select gap");
    a_idle_free: assert property (cmd_ready |-> !wr)
        else $error("write while idle");
    a_acq_wr_zero: assert property (take && cmd == CMD_ACQUIRE
        |-> ##4 wr && !data_out[0]) else $error("claim not write zero");
    a_rel_wr_one: assert property (take && cmd != CMD_ACQUIRE
        && cmd != CMD_POLL |-> ##4 wr && data_out[0])
        else $error("release not write one");
    a_poll_read: assert property (take && cmd == CMD_POLL
        |-> ##4 sel && !pins.output_enable_n && pins.read_write_n)
        else $error("poll not a read");
    c_acq: cover property (take && cmd == CMD_ACQUIRE);
    c_poll: cover property (take && cmd == CMD_POLL);
    c_init: cover property (take && cmd == CMD_INIT);
    c_done: cover property (result_valid);
endmodule // sem_host_props
bind sem_host sem_host_props i_props (.clk(clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .result_valid(result_valid), .pins(pins), .data_out(data_out),
    .data_oe(data_oe));

//--- bench/sem_dev_model.sv
`timescale 1ns/100ps
module sem_dev_model
    import sem_host_pkg::*;
(
    input wire pins_type pins,
    input wire logic [DATA_WIDTH-1:0] data_out,
    output logic [DATA_WIDTH-1:0] data_in,
    input wire logic b_we,
    input wire logic [INDEX_WIDTH-1:0] b_idx,
    input wire logic b_val
);
    // stale power-up state: this side holds every flag until init
    logic [FLAG_COUNT-1:0] req_a = '0, own_a = '1;
    logic [FLAG_COUNT-1:0] req_b = '1, own_b = '0;
    logic rd = 1'b1;
    wire acc = pins.chip_enable_n && !pins.semaphore_select_n;
    wire [2:0] ix = pins.address[2:0];
    function void settle(input int i);
        if (own_a[i] && req_a[i]) own_a[i] = 1'b0;
        if (own_b[i] && req_b[i]) own_b[i] = 1'b0;
        if (!own_a[i] && !own_b[i]) begin
            own_a[i] = !req_a[i];
            own_b[i] = req_a[i] && !req_b[i];
        end
    endfunction
    always @(negedge pins.read_write_n) if (acc) begin
        req_a[ix] = data_out[0];
        settle(ix);
    end
    always @(posedge b_we) begin
        req_b[b_idx] = b_val;
        settle(b_idx);
    end
    always @(negedge pins.output_enable_n)
        if (acc) rd = !own_a[ix];
    assign data_in = (acc && !pins.output_enable_n) ? {DATA_WIDTH{rd}}
        : {DATA_WIDTH{!rd}};
endmodule // sem_dev_model

//--- bench/sem_host_tb.sv
`timescale 1ns/100ps
module sem_host_tb;
    import sem_host_pkg::*;
    logic clk = 0, rst_n = 0, cmd_valid = 0, b_we = 0, b_val = 1;
    logic cmd_ready, result_valid;
    cmd_type cmd = CMD_INIT;
    logic [2:0] cmd_index = '0, b_idx = '0, k, j;
    result_type result;
    pins_type pins;
    logic [DATA_WIDTH-1:0] data_in, data_out, data_oe;
    logic [16:0] lfsr = 17'h1_69d1;
    int err_total = 0, total_checks = 0;
    always #5 clk = ~clk;
    sem_host i_sem_host (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .cmd_index(cmd_index), .result_valid(result_valid),
        .result(result), .pins(pins), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));
    sem_dev_model i_sem_dev_model (.pins(pins), .data_out(data_out),
        .data_in(data_in), .b_we(b_we), .b_idx(b_idx), .b_val(b_val));
    function automatic result_type exp_of(logic g, logic [2:0] i);
        return {g, i};
    endfunction
    function automatic logic [16:0] lfsr_next(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check(logic [4:0] seen, logic [4:0] want);
        total_checks++;
        if (seen !== want) begin
            err_total++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task final_report;
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(cmd_type c, logic [2:0] i, logic g, logic chk);
        logic [4:0] seen, want;
        @(posedge clk);
        #1 cmd = c;
        cmd_index = i;
        cmd_valid = 1;
        @(posedge clk);
        #1 cmd_valid = 0;
        repeat (100) begin
            if (result_valid) break;
            @(posedge clk);
            #1;
        end
        seen = {result_valid, result};
        want = {1'b1, exp_of(g, i)};
        if (!chk) begin
            seen[3:0] = 4'h0;
            want[3:0] = 4'h0;
        end
        check(seen, want);
    endtask
    task automatic other(logic [2:0] i, logic v);
        @(posedge clk);
        #1 b_idx = i;
        b_val = v;
        b_we = 1;
        @(posedge clk);
        #1 b_we = 0;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        run(CMD_INIT, 7, 0, 1);
        for (int n = 0; n < 8; n++) begin
            lfsr = lfsr_next(lfsr);
            k = lfsr[2:0];
            run(CMD_ACQUIRE, k, 1, 1);
            run(CMD_POLL, k, 1, 1);
            run(CMD_RELEASE, k, 0, 0);
            run(CMD_POLL, k, 0, 1);
        end
        j = lfsr[8:6];
        fork
            run(CMD_ACQUIRE, j, 0, 1);
            other(j, 0);
        join
        other(j, 1);
        run(CMD_POLL, j, 1, 1);
        run(CMD_RELEASE, j, 0, 0);
        run(CMD_POLL, j, 0, 1);
        k = lfsr[5:3];
        other(k, 0);
        run(CMD_ACQUIRE, k, 0, 1);
        run(CMD_POLL, k, 0, 1);
        other(k, 1);
        run(CMD_POLL, k, 1, 1);
        other(k, 1);
        run(CMD_POLL, k, 1, 1);
        other(k, 0);
        run(CMD_RELEASE, k, 0, 0);
        run(CMD_POLL, k, 0, 1);
        final_report;
    end
    initial begin
        #100000;
        err_total++;
        final_report;
    end
endmodule // sem_host_tb
